/* tc_buf2.sv */
/*
  small fifo with valid/ready on both sides; output data come from
  registers. default depth two, enough to absorb one stall of the sink.
  assumes: single clock, synchronous active-high reset.
*/
`timescale 1ns/10ps
module tc_buf2
  import tc_pkg::*;
#(
  parameter int W     = TC_OUT_W,
  parameter int DEPTH = TC_BUF_DEPTH
)
(
  input  wire logic         clk,
  input  wire logic         srst,
  input  wire logic         in_valid,
  output      logic         in_ready,
  input  wire logic [W-1:0] in_data,
  output      logic         out_valid,
  input  wire logic         out_ready,
  output      logic [W-1:0] out_data
);

  localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

  logic [W-1:0] mem_q [DEPTH];
  logic [W-1:0] mem_d [DEPTH];
  logic [PW-1:0] wr_q, wr_d, rd_q, rd_d;
  logic [PW:0]   cnt_q, cnt_d;
  logic          push, pop;

  initial
  begin
    if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0)
      $error("tc_buf2: depth must be a power of two, at least 2");
  end

  assign in_ready  = cnt_q != (PW+1)'(DEPTH);
  assign out_valid = cnt_q != '0;
  assign out_data  = mem_q[rd_q];
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;

  // ==========================================================
  // pointers and storage
  always_comb
  begin
    mem_d = mem_q;
    wr_d  = wr_q;
    rd_d  = rd_q;
    cnt_d = cnt_q;
    if (push)
    begin
      mem_d[wr_q] = in_data;
      wr_d        = wr_q + 1'b1;
    end
    if (pop)
      rd_d = rd_q + 1'b1;
    if (push && !pop)
      cnt_d = cnt_q + 1'b1;
    else if (pop && !push)
      cnt_d = cnt_q - 1'b1;
    if (srst)
    begin
      wr_d  = '0;
      rd_d  = '0;
      cnt_d = '0;
    end
  end

  always_ff @(posedge clk)
  begin
    mem_q <= mem_d;
    wr_q  <= wr_d;
    rd_q  <= rd_d;
    cnt_q <= cnt_d;
  end

  a_full_refuses : assert property (@(posedge clk) disable iff (srst) // [RULE_05]
    (out_valid && !out_ready && !in_ready) |=> !in_ready)
    else $error("buffer took a word while full and stalled");

endmodule

/* tc_correlator.sv */
/*
  transposed-form 32-tap correlator / convolver with two coefficient banks,
  full-precision accumulation, rounded barrel-shift output scaling and a
  cascade path for chaining identical units.
  assumes: all ports are on clk; the host fills the idle bank through the
  coefficient port and swaps banks with a one-cycle strobe; chained units
  share the input stream and feed casc_in from the previous unit's output.
*/
// Function
// [RULE_01] samples and coefficients are signed words of up to 16 bits and are the multiply operands.
// [RULE_02] the core has 32 multipliers, each with its own coefficient, feeding 32 delay-and-add stages.
// [RULE_03] each sample goes to all 32 multipliers in the same cycle.
// [RULE_04] each accepted sample adds every tap's product to the upstream partial sum and registers it.
// [RULE_05] from a cleared chain the outputs form the sliding dot product, newest input times last tap first.
// [RULE_06] coefficients sit in reversed order versus direct form so the output sequence is identical.
// [RULE_07] the host loads the reference left to right, the last sample in the last tap's register.
// [RULE_08] for a short reference the host writes zero into the unused leftmost taps.
// [RULE_09] the multipliers take their coefficients from the selected one of the coefficient sets.
// [RULE_10] identical units chain into a longer correlator with no glue between them.
// [RULE_11] the unit is reachable from a host as a peripheral through its load and stream ports.
// [RULE_12] two banks exist, one active and one host-accessible, and a swap strobe exchanges them.
// [RULE_13] accumulation keeps full precision and a shifter picks 24 rounded sign-extended bits.
// [RULE_14] a 32-stage 24-bit register delays the cascade input which is added to the scaled output.
// [RULE_15] for convolution the host loads the reference in the opposite order.
// [RULE_16] synchronous reset clears every stage and the chain moves one stage per accepted sample.
// [RULE_17] products and sums are signed and wide enough never to overflow over 32 taps.
`timescale 1ns/10ps
module tc_correlator
  import tc_pkg::*;
#(
  parameter int TAPS   = TC_TAPS,
  parameter int DW     = TC_DW,
  parameter int CW     = TC_CW,
  parameter int OUT_W  = TC_OUT_W,
  parameter int CASC_N = TC_CASC_DEPTH
)
(
  input  wire logic                    clk,
  input  wire logic                    srst,
  input  wire logic                    s_valid,
  output      logic                    s_ready,
  input  wire logic signed [DW-1:0]    s_data,
  output      logic                    m_valid,
  input  wire logic                    m_ready,
  output      logic [OUT_W-1:0]        m_data,
  input  wire logic [OUT_W-1:0]        casc_in,
  input  wire logic                    coef_we,
  input  wire logic [TC_ADDR_W-1:0]    coef_addr,
  input  wire logic signed [CW-1:0]    coef_wdata,
  output      logic [CW-1:0]           coef_rdata,
  input  wire logic                    bank_swap,
  output      logic                    active_bank,
  input  wire logic [TC_SHIFT_W-1:0]   shift_sel
);

  localparam int AW   = TC_ACC_W;
  localparam int SMAX = AW - OUT_W;

  initial
  begin
    if (TAPS != TC_TAPS || TAPS > (1 << TC_ADDR_W))
      $error("tc_correlator: tap count must match the address width");
    if (AW < DW + CW + $clog2(TAPS))
      $error("tc_correlator: accumulator too narrow for the tap count");
    if (SMAX < TC_SHIFT_MAX || CASC_N < 1)
      $error("tc_correlator: scaling or cascade depth unsupported");
  end

  // ==========================================================
  // coefficient banks and bank select
  logic signed [CW-1:0] bank_q [2][TAPS];
  logic signed [CW-1:0] bank_d [2][TAPS];
  logic                 act_q, act_d;
  logic [CW-1:0]        rdata_q, rdata_d;
  logic [TC_SHIFT_W-1:0] shift_q, shift_d;

  always_comb
  begin
    bank_d  = bank_q;
    act_d   = act_q;
    shift_d = shift_sel;
    rdata_d = bank_q[~act_q][coef_addr];
    if (coef_we)
      bank_d[~act_q][coef_addr] = coef_wdata;                // [RULE_12] [RULE_11]
    if (bank_swap)
      act_d = ~act_q;                                        // [RULE_12]
    if (srst)
    begin
      for (int b = 0; b < 2; b++)
        for (int t = 0; t < TAPS; t++)
          bank_d[b][t] = '0;
      act_d   = TC_BANK_RST;
      shift_d = TC_SHIFT_RST;
      rdata_d = '0;
    end
  end

  always_ff @(posedge clk)
  begin
    bank_q  <= bank_d;
    act_q   <= act_d;
    shift_q <= shift_d;
    rdata_q <= rdata_d;
  end

  assign active_bank = act_q;
  assign coef_rdata  = rdata_q;

  // ==========================================================
  // transposed delay-and-add chain
  logic                 accept;
  logic signed [AW-1:0] acc    [TAPS];
  logic signed [AW-1:0] acc_in [TAPS];

  assign accept = s_valid && s_ready;

  generate
    for (genvar i = 0; i < TAPS; i++)
    begin : g_tap
      if (i == 0)
      begin : g_head
        assign acc_in[i] = '0;
      end
      else
      begin : g_link
        assign acc_in[i] = acc[i-1];                         // [RULE_04] [RULE_06]
      end
      tc_tap #(
        .DW (DW),
        .CW (CW),
        .AW (AW)
      ) u_tap (
        .clk     (clk),
        .srst    (srst),
        .adv     (accept),                                   // [RULE_16]
        .sample  (s_data),                                   // [RULE_03]
        .coef    (bank_q[act_q][i]),                         // [RULE_09] [RULE_02]
        .acc_in  (acc_in[i]),
        .acc_out (acc[i])
      );
    end
  endgenerate

  // ==========================================================
  // cascade delay line
  logic [OUT_W-1:0] casc_q [CASC_N];
  logic [OUT_W-1:0] casc_d [CASC_N];
  logic [OUT_W-1:0] chold_q, chold_d;

  always_comb
  begin
    casc_d  = casc_q;
    chold_d = chold_q;
    if (accept)
    begin
      chold_d   = casc_q[CASC_N-1];                          // [RULE_14] [RULE_10]
      casc_d[0] = casc_in;
      for (int k = 1; k < CASC_N; k++)
        casc_d[k] = casc_q[k-1];
    end
    if (srst)
    begin
      for (int k = 0; k < CASC_N; k++)
        casc_d[k] = '0;
      chold_d = '0;
    end
  end

  always_ff @(posedge clk)
  begin
    casc_q  <= casc_d;
    chold_q <= chold_d;
  end

  // ==========================================================
  // output scaling with rounding, then cascade sum
  logic [TC_SHIFT_W-1:0] sh;
  logic signed [AW:0]    rnd;
  logic signed [AW:0]    wide;
  logic signed [AW:0]    shifted;
  logic [OUT_W-1:0]      out_word;

  always_comb
  begin
    sh = (shift_q > TC_SHIFT_W'(TC_SHIFT_MAX)) ? TC_SHIFT_W'(TC_SHIFT_MAX) : shift_q;
    rnd = '0;
    if (sh != '0)
      rnd = (AW+1)'(1) <<< (sh - 1'b1);                       // [RULE_13]
    wide     = (AW+1)'(acc[TAPS-1]) + rnd;
    shifted  = wide >>> sh;                                  // [RULE_13]
    out_word = shifted[OUT_W-1:0] + chold_q;                 // [RULE_14]
  end

  // ==========================================================
  // result hand-off into the two-entry buffer
  logic pend_q, pend_d;
  logic buf_ready;

  always_comb
  begin
    pend_d = pend_q;
    if (accept)
      pend_d = 1'b1;                                         // [RULE_05]
    else if (buf_ready)
      pend_d = 1'b0;
    if (srst)
      pend_d = TC_PEND_RST;
  end

  always_ff @(posedge clk)
  begin
    pend_q <= pend_d;
  end

  assign s_ready = !srst && (!pend_q || buf_ready);

  tc_buf2 #(
    .W     (OUT_W),
    .DEPTH (TC_BUF_DEPTH)
  ) u_buf (
    .clk       (clk),
    .srst      (srst),
    .in_valid  (pend_q),
    .in_ready  (buf_ready),
    .in_data   (out_word),
    .out_valid (m_valid),
    .out_ready (m_ready),
    .out_data  (m_data)
  );

  // ==========================================================
  // checks
  a_reset_clears : assert property (@(posedge clk)                        // [RULE_16]
    srst |=> (acc[0] == '0 && acc[TAPS-1] == '0 && !pend_q))
    else $error("chain not cleared by reset");

  a_reset_drains : assert property (@(posedge clk)                        // [RULE_16]
    srst |=> !m_valid)
    else $error("result stream not emptied by reset");

  a_ready_in_reset : assert property (@(posedge clk)                      // [RULE_16]
    srst |-> !s_ready)
    else $error("sample slot open during reset");

  a_head_product : assert property (@(posedge clk) disable iff (srst)     // [RULE_03]
    accept |=> acc[0] == AW'($past(s_data) * $past(bank_q[act_q][0])))
    else $error("first stage does not hold the new product");

  a_mid_sum : assert property (@(posedge clk) disable iff (srst)          // [RULE_04]
    accept |=> acc[TAPS/2] ==
      $past(acc[TAPS/2-1]) + AW'($past(s_data) * $past(bank_q[act_q][TAPS/2])))
    else $error("middle stage did not add its product to upstream sum");

  a_tail_sum : assert property (@(posedge clk) disable iff (srst)         // [RULE_04]
    accept |=> acc[TAPS-1] ==
      $past(acc[TAPS-2]) + AW'($past(s_data) * $past(bank_q[act_q][TAPS-1])))
    else $error("last stage did not add its product to upstream sum");

  a_chain_still : assert property (@(posedge clk) disable iff (srst)      // [RULE_16]
    !accept |=> $stable(acc[TAPS-1]) && $stable(acc[TAPS/2]))
    else $error("chain moved without an accepted sample");

  a_swap_flips : assert property (@(posedge clk) disable iff (srst)       // [RULE_12]
    bank_swap |=> active_bank != $past(active_bank))
    else $error("bank swap did not exchange banks");

  a_bank_steady : assert property (@(posedge clk) disable iff (srst)      // [RULE_12]
    !bank_swap |=> $stable(act_q))
    else $error("active bank changed without a swap");

  a_idle_bank_write : assert property (@(posedge clk) disable iff (srst)  // [RULE_12]
    coef_we |=> bank_q[~$past(act_q)][$past(coef_addr)] == $past(coef_wdata))
    else $error("coefficient write missed the idle bank");

  a_active_untouched : assert property (@(posedge clk) disable iff (srst) // [RULE_12]
    (coef_we && !bank_swap) |=>
      bank_q[act_q][$past(coef_addr)] == $past(bank_q[act_q][coef_addr]))
    else $error("coefficient write reached the active bank");

  a_idle_readback : assert property (@(posedge clk) disable iff (srst)    // [RULE_12]
    1'b1 |=> coef_rdata == $past(bank_q[~act_q][coef_addr]))
    else $error("readback does not show the idle bank");

  a_casc_delay : assert property (@(posedge clk) disable iff (srst)       // [RULE_14]
    accept |=> chold_q == $past(casc_q[CASC_N-1]))
    else $error("cascade term not taken from the delay line end");

  a_casc_entry : assert property (@(posedge clk) disable iff (srst)       // [RULE_10]
    accept |=> casc_q[0] == $past(casc_in))
    else $error("cascade input not captured on an accepted sample");

  a_casc_still : assert property (@(posedge clk) disable iff (srst)       // [RULE_14]
    !accept |=> $stable(chold_q) && $stable(casc_q[0]))
    else $error("cascade line moved without an accepted sample");

  a_result_pending : assert property (@(posedge clk) disable iff (srst)   // [RULE_05]
    accept |=> pend_q)
    else $error("accepted sample produced no pending result");

  a_pend_drains : assert property (@(posedge clk) disable iff (srst)      // [RULE_05]
    (pend_q && buf_ready && !accept) |=> !pend_q)
    else $error("pending result not handed to the buffer");

  a_stall_holds : assert property (@(posedge clk) disable iff (srst)      // [RULE_05]
    (pend_q && !buf_ready) |-> !s_ready ##1 pend_q)
    else $error("sample taken while result blocked");

endmodule

/* tc_correlator_tb.sv */
/*
  self-checking bench of the correlator: loads coefficients, streams samples,
  predicts each result and compares it as the sink takes it.
  assumes: tc_pkg and tc_sink_model are compiled first.
*/
`timescale 1ns/10ps
module tc_correlator_tb
  import tc_pkg::*;
;
  // ==========================================================
  // signals
  logic                    clk, srst, s_valid, s_ready, m_valid, m_ready;
  logic                    coef_we, bank_swap, active_bank;
  logic signed [TC_DW-1:0] s_data, coef_wdata;
  logic [TC_OUT_W-1:0]     m_data, casc_in;
  logic [TC_ADDR_W-1:0]    coef_addr;
  logic [TC_CW-1:0]        coef_rdata;
  logic [TC_SHIFT_W-1:0]   shift_sel;
  logic [6:0]              stall_pct;
  logic signed [TC_CW-1:0] cf [TC_TAPS];
  logic signed [TC_DW-1:0] hy [$];
  logic [TC_OUT_W-1:0]     hc [$];
  logic [TC_OUT_W-1:0]     expq [$];
  int                      miscompares, samples_checked, cyc;

  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  tc_correlator u_dut (
    .clk        (clk),
    .srst       (srst),
    .s_valid    (s_valid),
    .s_ready    (s_ready),
    .s_data     (s_data),
    .m_valid    (m_valid),
    .m_ready    (m_ready),
    .m_data     (m_data),
    .casc_in    (casc_in),
    .coef_we    (coef_we),
    .coef_addr  (coef_addr),
    .coef_wdata (coef_wdata),
    .coef_rdata (coef_rdata),
    .bank_swap  (bank_swap),
    .active_bank(active_bank),
    .shift_sel  (shift_sel)
  );

  tc_sink_model u_sink (
    .clk      (clk),
    .srst     (srst),
    .stall_pct(stall_pct),
    .m_ready  (m_ready)
  );

  // ==========================================================
  // reporting
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp)
    begin
      miscompares++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic complete_run();
    $display("checked %0d mismatches %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  // ==========================================================
  // result monitor and cycle limit
  always @(posedge clk)
  begin
    cyc <= cyc + 1;
    if (cyc == 20000)
    begin
      miscompares++;
      complete_run();
    end
    if (m_valid === 1'b1 && m_ready === 1'b1)
    begin
      if (expq.size() == 0)
        check(m_data, 32'hff000000);
      else
        check(m_data, expq.pop_front());
    end
  end

  // ==========================================================
  // reference: sliding dot product, last tap sees the newest sample
  function automatic logic [TC_OUT_W-1:0] predict(input int n, input int s);
    longint              acc;
    logic [TC_OUT_W-1:0] c;
    acc = 0;
    for (int i = 0; i < TC_TAPS; i++)
      if (n - TC_TAPS + 1 + i >= 0)
        acc += longint'(cf[i]) * longint'(hy[n - TC_TAPS + 1 + i]);
    if (s > 0)
      acc = (acc + (longint'(1) <<< (s - 1))) >>> s;
    c = (n >= TC_CASC_DEPTH) ? hc[n - TC_CASC_DEPTH] : '0;
    return acc[TC_OUT_W-1:0] + c;
  endfunction

  // ==========================================================
  // coefficient load into the idle bank, readback, swap
  task automatic load(input int kind);
    logic signed [TC_CW-1:0] x;
    cf = '{default: '0};
    for (int i = 0; i < TC_TAPS && kind != 4; i++)
    begin
      x = (kind == 3) ? 16'sh8000 : 16'($urandom);
      if (kind == 1 && i < 2)
        x = '0;
      cf[kind == 2 ? TC_TAPS - 1 - i : i] = x;
    end
    for (int i = 0; i < TC_TAPS && kind != 4; i++)
    begin
      coef_we = 1'b1;
      coef_addr = i[TC_ADDR_W-1:0];
      coef_wdata = cf[i];
      @(negedge clk);
    end
    coef_we = 1'b0;
    for (int i = 0; i < TC_TAPS; i++)
    begin
      coef_addr = i[TC_ADDR_W-1:0];
      @(negedge clk);
      check({16'h0, coef_rdata}, {16'h0, cf[i]});
    end
    bank_swap = (kind != 4);
    @(negedge clk);
    bank_swap = 1'b0;
    check(active_bank, kind != 4);
    @(negedge clk);
    check(coef_rdata, 32'h0);
  endtask

  // ==========================================================
  // one test: reset, load, stream n samples, drain
  task automatic run(input int kind, input int n, input int s, input bit stall,
                     input bit casc);
    int t;
    bit refused;
    refused = 1'b0;
    srst = 1'b1;
    shift_sel = s[TC_SHIFT_W-1:0];
    stall_pct = stall ? 7'd100 : 7'd0;
    repeat (2) @(negedge clk);
    srst = 1'b0;
    hy.delete();
    hc.delete();
    load(kind);
    for (int k = 0; k < n; k++)
    begin
      s_valid = 1'b1;
      s_data = (kind == 3) ? 16'sh8000 : 16'($urandom);
      casc_in = casc ? 24'($urandom) : '0;
      t = 0;
      // s_ready is settled between edges; a high value here means the next edge accepts
      while (s_ready !== 1'b1 && t < 50)
      begin
        @(negedge clk);
        t++;
        if (t == 4)
          stall_pct = 7'd60;
      end
      if (t > 0)
        refused = 1'b1;
      @(posedge clk);
      hy.push_back(s_data);
      hc.push_back(casc_in);
      expq.push_back(predict(k, s > TC_SHIFT_MAX ? TC_SHIFT_MAX : s));
      @(negedge clk);
    end
    s_valid = 1'b0;
    t = 0;
    while (expq.size() > 0 && t < 500)
    begin
      @(negedge clk);
      t++;
    end
    check(expq.size(), 32'h0);
    check(refused, stall);
    $display("test kind %0d samples %0d shift %0d done", kind, n, s);
  endtask

  // ==========================================================
  // main sequence
  initial
  begin
    cyc = 0;
    miscompares = 0;
    samples_checked = 0;
    srst = 1'b1;
    s_valid = 1'b0;
    s_data = '0;
    casc_in = '0;
    coef_we = 1'b0;
    coef_addr = '0;
    coef_wdata = '0;
    bank_swap = 1'b0;
    shift_sel = '0;
    stall_pct = 7'd0;
    repeat (8) @(negedge clk);
    void'($urandom(32'h383f734b));
    run(0, 40, 0, 1'b0, 1'b0);
    run(1, 40, 5, 1'b0, 1'b0);
    run(2, 40, 13, 1'b1, 1'b0);
    run(3, 40, 15, 1'b0, 1'b0);
    run(4, 70, 0, 1'b0, 1'b1);
    run(0, 70, 3, 1'b1, 1'b1);
    complete_run();
  end
endmodule

/* tc_pkg.sv */
/*
  shared constants of the transposed 32-tap correlator: widths, depths,
  reset values and the output scaling range.
  assumes: imported whole by every module of the correlator.
*/
package tc_pkg;

  // ==========================================================
  // datapath geometry
  localparam int TC_TAPS       = 32;
  localparam int TC_DW         = 16;
  localparam int TC_CW         = 16;
  localparam int TC_ADDR_W     = 5;
  localparam int TC_ACC_W      = 37;
  localparam int TC_OUT_W      = 24;

  // ==========================================================
  // output scaling
  localparam int TC_SHIFT_W    = 4;
  localparam int TC_SHIFT_MAX  = 13;

  // ==========================================================
  // cascade and buffering
  localparam int TC_CASC_DEPTH = 32;
  localparam int TC_BUF_DEPTH  = 2;

  // ==========================================================
  // reset values
  localparam logic       TC_BANK_RST  = 1'b0;
  localparam logic [3:0] TC_SHIFT_RST = 4'h0;
  localparam logic       TC_PEND_RST  = 1'b0;

endpackage

/* tc_sink_model.sv */
/*
  sink model for the result stream: takes words at a random stall rate.
  assumes: same clock as the correlator, ready changed on the falling edge.
*/
`timescale 1ns/10ps
module tc_sink_model
(
  input  wire logic       clk,
  input  wire logic       srst,
  input  wire logic [6:0] stall_pct,
  output      logic       m_ready
);
  // ==========================================================
  // ready pattern, 100 stalls fully
  always @(negedge clk)
  begin
    m_ready <= !srst && ($urandom_range(99) >= stall_pct);
  end
endmodule

/* tc_tap.sv */
/*
  one delay-and-add stage of the transposed chain: multiplies the common
  sample by its own coefficient and adds the partial sum from upstream.
  assumes: adv is a one-cycle accept strobe from the same clock domain.
*/
`timescale 1ns/10ps
module tc_tap
  import tc_pkg::*;
#(
  parameter int DW = TC_DW,
  parameter int CW = TC_CW,
  parameter int AW = TC_ACC_W
)
(
  input  wire logic                 clk,
  input  wire logic                 srst,
  input  wire logic                 adv,
  input  wire logic signed [DW-1:0] sample,
  input  wire logic signed [CW-1:0] coef,
  input  wire logic signed [AW-1:0] acc_in,
  output      logic signed [AW-1:0] acc_out
);

  logic signed [DW+CW-1:0] prod;
  logic signed [AW-1:0]    acc_d;
  logic signed [AW-1:0]    acc_q;

  initial
  begin
    if (AW < DW + CW)
      $error("tc_tap: accumulator narrower than a product");
  end

  // ==========================================================
  // stage arithmetic
  always_comb
  begin
    prod  = sample * coef;                                   // [RULE_01] [RULE_17]
    acc_d = acc_q;
    if (srst)
      acc_d = '0;                                            // [RULE_16]
    else if (adv)
      acc_d = acc_in + AW'(prod);                            // [RULE_04]
  end

  always_ff @(posedge clk)
  begin
    acc_q <= acc_d;
  end

  assign acc_out = acc_q;

  a_tap_holds : assert property (@(posedge clk) disable iff (srst)   // [RULE_16]
    !adv |=> acc_q == $past(acc_q))
    else $error("tap changed without an accepted sample");

endmodule
